/* File: rtl/sbsp_consts.svh */
// Purpose: Shared constants of the synchronous burst SRAM port
// Assumes: Included by its bare name from the memory and host design files
// Notes:   Definitions only; guarded against double inclusion
`ifndef SBSP_CONSTS_SVH
`define SBSP_CONSTS_SVH

// ****************************************************************
// Organisation defaults (256K words of 36 bits)
// ****************************************************************
`define SBSP_DEF_ADDR_W  18
`define SBSP_DEF_LANES   4
`define SBSP_DEF_LANE_W  9

// ****************************************************************
// Burst and read timing, in clock edges
// ****************************************************************
`define SBSP_CNT_W       2
`define SBSP_BURST_LAST  2'h3
`define SBSP_LAT_FLOW    1
`define SBSP_LAT_PIPE    2

`endif

/* File: rtl/sbsp_pkg.sv */
// Purpose: Types shared by both ends of the burst SRAM port
// Assumes: sbsp_consts.svh holds the numbers
// Notes:   Types only
package sbsp_pkg;

    // ****************************************************************
    // Cycle kinds seen by the memory at each clock edge
    // ****************************************************************
    typedef enum logic [2:0] {
        SBSP_CYC_IDLE  = 3'b000,
        SBSP_CYC_DESEL = 3'b001,
        SBSP_CYC_READ  = 3'b010,
        SBSP_CYC_WRITE = 3'b011,
        SBSP_CYC_SLEEP = 3'b100
    } sbsp_cyc_e;

    // ****************************************************************
    // Host sequencer states
    // ****************************************************************
    typedef enum logic [0:0] {
        SBSP_HS_IDLE  = 1'b0,
        SBSP_HS_BURST = 1'b1
    } sbsp_host_st_e;

endpackage : sbsp_pkg

/* File: rtl/sbsp_if.sv */
// Purpose: Pin bundle between the burst SRAM and its host
// Assumes: Both ends run on the same clock
// Notes:   The shared data wire is resolved here from the two enables
`timescale 1ns/1ns
`default_nettype none
interface sbsp_if #(
    parameter int ADDR_W = 18,
    parameter int LANES  = 4,
    parameter int LANE_W = 9
) ();
    localparam int DW = LANES * LANE_W;

    logic [ADDR_W-1:0] addr;
    logic              chip_sel_low_n;
    logic              chip_sel_high;
    logic              proc_addr_strobe_n;
    logic              ctrl_addr_strobe_n;
    logic              burst_advance_n;
    logic              global_write_n;
    logic              byte_write_en_n;
    logic [LANES-1:0]  lane_write_en_n;
    logic              out_en_n;
    logic              sleep_request;
    logic              linear_order_n;
    logic              flowthru_select_n;
    logic [DW-1:0]     host_dq;
    logic              host_dq_oe_n;
    logic [DW-1:0]     dev_dq;
    logic              dev_dq_oe_n;
    wire  [DW-1:0]     dq;

    // Device wins if both drive; a clash is a host fault
    // Released bus shows the inverse of the last device word, so a late sample fails
    assign dq = !dev_dq_oe_n ? dev_dq : (!host_dq_oe_n ? host_dq : ~dev_dq);

    modport dev (
        input  addr, chip_sel_low_n, chip_sel_high, proc_addr_strobe_n,
        input  ctrl_addr_strobe_n, burst_advance_n, global_write_n,
        input  byte_write_en_n, lane_write_en_n, out_en_n, sleep_request,
        input  linear_order_n, flowthru_select_n, dq,
        output dev_dq, dev_dq_oe_n
    );

    modport host (
        output addr, chip_sel_low_n, chip_sel_high, proc_addr_strobe_n,
        output ctrl_addr_strobe_n, burst_advance_n, global_write_n,
        output byte_write_en_n, lane_write_en_n, out_en_n, sleep_request,
        output linear_order_n, flowthru_select_n, host_dq, host_dq_oe_n,
        input  dq
    );
endinterface : sbsp_if
`default_nettype wire

/* File: rtl/sbsp_sram.sv */
// Purpose: Synchronous burst SRAM core with its pin-side control logic
// Assumes: All pins except out_en_n, sleep_request and flowthru_select_n are sampled on clock_i
// Notes:   Memory contents are never touched by reset or by sleep
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.svh"
module sbsp_sram
    import sbsp_pkg::*;
#(
    parameter int ADDR_W = `SBSP_DEF_ADDR_W,
    parameter int LANES  = `SBSP_DEF_LANES,
    parameter int LANE_W = `SBSP_DEF_LANE_W
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    sbsp_if.dev       pins,
    output var  logic asleep_o,
    output var  logic access_o
);

    localparam int DW    = LANES * LANE_W;
    localparam int HI_W  = ADDR_W - `SBSP_CNT_W;
    localparam int DEPTH = 1 << ADDR_W;

    // ****************************************************************
    // Build check
    // ****************************************************************
    // Widths are the three documented organisations; address may shrink
    initial begin
        if (!((LANES == 2 && LANE_W == 9) || (LANES == 4 && (LANE_W == 8 || LANE_W == 9))))
            $error("sbsp_sram: unsupported organisation");
        if (ADDR_W < 3 || ADDR_W > 19)
            $error("sbsp_sram: unsupported address width");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                  active;
        logic [`SBSP_CNT_W-1:0] base_lo;
        logic [`SBSP_CNT_W-1:0] cnt;
        logic [HI_W-1:0]       addr_hi;
        logic                  rd_now;
        logic [DW-1:0]         flow_data;
        logic                  pipe_vld;
        logic [DW-1:0]         pipe_data;
    } sbsp_sram_s;

    sbsp_sram_s s_q;
    sbsp_sram_s s_d;

    logic [DW-1:0] mem [DEPTH];

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [`SBSP_CNT_W-1:0] burst_lo(
        input logic [`SBSP_CNT_W-1:0] base,
        input logic [`SBSP_CNT_W-1:0] cnt,
        input logic                   lin_n
    );
        logic [`SBSP_CNT_W-1:0] r;
        if (!lin_n) begin
            r = base + cnt;
        end else begin
            r = base ^ cnt;
        end
        return r;
    endfunction : burst_lo

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic             sel;
    logic             strobe;
    logic             wr_any;
    logic [LANES-1:0] lane_we;
    sbsp_cyc_e        cyc;
    logic [ADDR_W-1:0] acc_addr;

    always_comb begin
        sel     = !pins.chip_sel_low_n && pins.chip_sel_high;
        strobe  = !pins.proc_addr_strobe_n || !pins.ctrl_addr_strobe_n;
        wr_any  = !pins.global_write_n || !pins.byte_write_en_n;
        if (!pins.global_write_n) begin
            lane_we = {LANES{1'b1}};
        end else if (!pins.byte_write_en_n) begin
            lane_we = ~pins.lane_write_en_n;
        end else begin
            lane_we = '0;
        end
        s_d           = s_q;
        s_d.rd_now    = 1'b0;
        // Single-cycle deselect: output stage follows reads only
        s_d.pipe_vld  = s_q.rd_now;
        s_d.pipe_data = s_q.flow_data;
        cyc           = SBSP_CYC_IDLE;
        if (pins.sleep_request) begin
            // Commands ignored in sleep; burst state and array held
            cyc          = SBSP_CYC_SLEEP;
            s_d.pipe_vld = 1'b0;
        end else if (strobe) begin
            if (!sel) begin
                cyc        = SBSP_CYC_DESEL;
                s_d.active = 1'b0;
            end else begin
                // Fresh address every strobe, no penalty cycle
                s_d.active  = 1'b1;
                s_d.addr_hi = pins.addr[ADDR_W-1:`SBSP_CNT_W];
                s_d.base_lo = pins.addr[`SBSP_CNT_W-1:0];
                s_d.cnt     = '0;
                // A processor strobe always opens with a read
                if (pins.proc_addr_strobe_n && wr_any) begin
                    cyc = SBSP_CYC_WRITE;
                end else begin
                    cyc = SBSP_CYC_READ;
                end
            end
        end else if (s_q.active) begin
            if (!pins.burst_advance_n) begin
                s_d.cnt = s_q.cnt + 2'h1;
            end
            cyc = wr_any ? SBSP_CYC_WRITE : SBSP_CYC_READ;
        end
        acc_addr = {s_d.addr_hi, burst_lo(s_d.base_lo, s_d.cnt, pins.linear_order_n)};
        if (cyc == SBSP_CYC_READ) begin
            s_d.rd_now    = 1'b1;
            // Captured at the access edge so flow-through data is out that cycle
            s_d.flow_data = mem[acc_addr];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Array write
    // ****************************************************************
    // Data taken on the command edge; no host handshake follows
    always_ff @(posedge clock_i) begin
        if (rst_n_i && cyc == SBSP_CYC_WRITE) begin
            for (int l = 0; l < LANES; l++) begin
                if (lane_we[l]) begin
                    mem[acc_addr][l*LANE_W +: LANE_W] <= pins.dq[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ****************************************************************
    // Data outputs
    // ****************************************************************
    // Output enable and sleep act without the clock
    logic drive;

    always_comb begin
        drive = pins.flowthru_select_n ? s_q.pipe_vld : s_q.rd_now;
        pins.dev_dq_oe_n = !(drive && !pins.out_en_n && !pins.sleep_request);
        pins.dev_dq      = pins.flowthru_select_n ? s_q.pipe_data : s_q.flow_data;
        asleep_o         = pins.sleep_request;
        access_o         = s_q.active;
    end

endmodule : sbsp_sram
`default_nettype wire

/* File: rtl/sbsp_host.sv */
// Purpose: Host end driving the burst SRAM pins from simple requests
// Assumes: Same clock as the memory; straps and sleep come from the user
// Notes:   One request at a time; a read burst returns four words
//
// Our own choices: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "sbsp_consts.svh"
module sbsp_host
    import sbsp_pkg::*;
#(
    parameter int ADDR_W = `SBSP_DEF_ADDR_W,
    parameter int LANES  = `SBSP_DEF_LANES,
    parameter int LANE_W = `SBSP_DEF_LANE_W
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    sbsp_if.host                         pins,
    input  wire logic                    req_valid_i,
    input  wire logic                    req_write_i,
    input  wire logic                    req_burst_i,
    input  wire logic [ADDR_W-1:0]       req_addr_i,
    input  wire logic [LANES*LANE_W-1:0] req_wdata_i,
    input  wire logic [LANES-1:0]        req_lane_en_i,
    input  wire logic                    linear_order_n_i,
    input  wire logic                    flowthru_select_n_i,
    input  wire logic                    sleep_i,
    output var  logic                    req_ready_o,
    output var  logic [LANES*LANE_W-1:0] rdata_o,
    output var  logic                    rdata_valid_o
);

    localparam int DW = LANES * LANE_W;

    initial begin
        if (ADDR_W < 3 || !(LANES == 2 || LANES == 4)) begin
            $error("sbsp_host: unsupported organisation");
        end
    end

    // ****************************************************************
    // State: all pins except sleep and the two straps come from flip-flops
    // ****************************************************************
    typedef struct packed {
        sbsp_host_st_e          st;
        logic [`SBSP_CNT_W-1:0] beat;
        logic [ADDR_W-1:0]      addr;
        logic                   csl_n;
        logic                   csh;
        logic                   ps_n;
        logic                   cs_n;
        logic                   adv_n;
        logic                   gw_n;
        logic                   bw_n;
        logic [LANES-1:0]       lane_n;
        logic                   oe_n;
        logic [DW-1:0]          dq;
        logic                   dq_oe_n;
        logic                   pin_rd;
        logic                   rd1;
        logic                   rd2;
        logic [DW-1:0]          rdata;
        logic                   rvalid;
    } sbsp_host_s;

    sbsp_host_s s_q;
    sbsp_host_s s_d;
    logic       ready;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        // Waits for reads to drain so a write never meets read data on the bus
        ready    = s_q.st == SBSP_HS_IDLE && !s_q.pin_rd && !s_q.rd1 && !s_q.rd2;
        s_d      = s_q;
        s_d.rd1  = s_q.pin_rd;
        s_d.rd2  = s_q.rd1;
        s_d.rvalid = !flowthru_select_n_i ? s_q.rd1 : s_q.rd2;
        if (s_d.rvalid) begin
            s_d.rdata = pins.dq;
        end
        // Idle cycles deselect the part
        s_d.csl_n   = 1'b1;
        s_d.csh     = 1'b0;
        s_d.ps_n    = 1'b1;
        s_d.cs_n    = 1'b0;
        s_d.adv_n   = 1'b1;
        s_d.gw_n    = 1'b1;
        s_d.bw_n    = 1'b1;
        s_d.lane_n  = {LANES{1'b1}};
        s_d.oe_n    = 1'b0;
        s_d.dq_oe_n = 1'b1;
        s_d.pin_rd  = 1'b0;
        unique case (s_q.st)
            SBSP_HS_IDLE: begin
                if (req_valid_i && ready) begin
                    s_d.addr  = req_addr_i;
                    s_d.csl_n = 1'b0;
                    s_d.csh   = 1'b1;
                    if (req_write_i) begin
                        s_d.cs_n    = 1'b0;
                        s_d.gw_n    = !(&req_lane_en_i);
                        s_d.bw_n    = &req_lane_en_i;
                        s_d.lane_n  = ~req_lane_en_i;
                        s_d.dq      = req_wdata_i;
                        s_d.dq_oe_n = 1'b0;
                        s_d.oe_n    = 1'b1;
                    end else begin
                        s_d.cs_n   = 1'b1;
                        s_d.ps_n   = 1'b0;
                        s_d.pin_rd = 1'b1;
                        if (req_burst_i) begin
                            s_d.st   = SBSP_HS_BURST;
                            s_d.beat = 2'h1;
                        end
                    end
                end
            end
            SBSP_HS_BURST: begin
                s_d.csl_n  = 1'b0;
                s_d.csh    = 1'b1;
                s_d.cs_n   = 1'b1;
                s_d.adv_n  = 1'b0;
                s_d.pin_rd = 1'b1;
                s_d.beat   = s_q.beat + 2'h1;
                if (s_q.beat == `SBSP_BURST_LAST) begin
                    s_d.st = SBSP_HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_q <= '{st: SBSP_HS_IDLE, csl_n: 1'b1, ps_n: 1'b1, adv_n: 1'b1,
                     gw_n: 1'b1, bw_n: 1'b1, lane_n: {LANES{1'b1}},
                     dq_oe_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Pins and user side
    // ****************************************************************
    always_comb begin
        pins.addr               = s_q.addr;
        pins.chip_sel_low_n     = s_q.csl_n;
        pins.chip_sel_high      = s_q.csh;
        pins.proc_addr_strobe_n = s_q.ps_n;
        pins.ctrl_addr_strobe_n = s_q.cs_n;
        pins.burst_advance_n    = s_q.adv_n;
        pins.global_write_n     = s_q.gw_n;
        pins.byte_write_en_n    = s_q.bw_n;
        pins.lane_write_en_n    = s_q.lane_n;
        pins.out_en_n           = s_q.oe_n;
        pins.host_dq            = s_q.dq;
        pins.host_dq_oe_n       = s_q.dq_oe_n;
        pins.sleep_request      = sleep_i;
        pins.linear_order_n     = linear_order_n_i;
        pins.flowthru_select_n  = flowthru_select_n_i;
        req_ready_o             = ready;
        rdata_o                 = s_q.rdata;
        rdata_valid_o           = s_q.rvalid;
    end

endmodule : sbsp_host
`default_nettype wire

/* File: dv/sbsp_checker_properties.sv */
// Purpose: Pin-level checks between the burst SRAM and its host
// Assumes: One clock; straps change only while the pins are idle
// Notes:   Sees the interface signals as plain inputs
`timescale 1ns/1ns
`default_nettype none
module sbsp_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic chip_sel_low_n,
    input wire logic chip_sel_high,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic global_write_n,
    input wire logic byte_write_en_n,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic flowthru_select_n,
    input wire logic host_dq_oe_n,
    input wire logic dev_dq_oe_n
);
    logic sel;
    logic strobe;
    logic desel;
    logic rd_new;

    // ****************************************************************
    // Decoded commands
    // ****************************************************************
    assign sel    = !chip_sel_low_n && chip_sel_high;
    assign strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    // Sleep holds state, so commands seen in sleep are left out
    assign desel  = strobe && !sel && !sleep_request;
    assign rd_new = strobe && sel && !sleep_request && !out_en_n
                    && (!proc_addr_strobe_n || (global_write_n && byte_write_en_n));

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************************************************
    // Properties
    // ****************************************************************
    oe_gate_a: assert property (out_en_n |-> dev_dq_oe_n)
        else $error("outputs driven with output enable high");
    sleep_off_a: assert property (sleep_request |-> dev_dq_oe_n)
        else $error("outputs driven in sleep");
    flow_desel_a: assert property (desel && !flowthru_select_n |=> dev_dq_oe_n)
        else $error("flow deselect late");
    pipe_desel_a: assert property (desel && flowthru_select_n |-> ##2 dev_dq_oe_n)
        else $error("pipeline deselect late");
    flow_read_a: assert property (rd_new && !flowthru_select_n
        |=> (!dev_dq_oe_n || out_en_n || sleep_request))
        else $error("flow read not driven next cycle");
    pipe_read_a: assert property (rd_new && flowthru_select_n
        |-> ##2 (!dev_dq_oe_n || out_en_n || sleep_request))
        else $error("pipeline read not driven two cycles on");
    host_drive_a: assert property (!host_dq_oe_n |-> (!global_write_n || !byte_write_en_n))
        else $error("host drives data outside a write");
    no_clash_a: assert property (!host_dq_oe_n |-> dev_dq_oe_n)
        else $error("both ends drive data");
    gw_data_a: assert property (!global_write_n && strobe && sel |-> !host_dq_oe_n)
        else $error("global write without data");
    reset_idle_a: assert property ($rose(rst_n_i)
        |-> (chip_sel_low_n && host_dq_oe_n && dev_dq_oe_n))
        else $error("pins not idle after reset");

    cover property (rd_new && flowthru_select_n);
    cover property (rd_new && !flowthru_select_n);
    cover property (!global_write_n && sel);
    cover property (!byte_write_en_n && global_write_n && sel);
endmodule : sbsp_checker
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench joining host and memory ends
// Assumes: Small address width; straps changed only while idle
// Notes:   A model array tracks expected memory contents
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sbsp_pkg::*;
    localparam int AW = 4;
    localparam int LN = 4;
    localparam int LW = 9;
    localparam int DW = LN * LW;
    logic          clock_i   = 1'b0;
    logic          rst_n_i   = 1'b0;
    logic          req_valid = 1'b0;
    logic          req_write = 1'b0;
    logic          req_burst = 1'b0;
    logic [AW-1:0] req_addr  = '0;
    logic [DW-1:0] req_wdata = '0;
    logic [LN-1:0] req_lane  = '0;
    logic          linear_n  = 1'b0;
    logic          flow_n    = 1'b1;
    logic          sleep     = 1'b0;
    logic          req_ready;
    logic [DW-1:0] rdata;
    logic          rdata_valid;
    logic          asleep;
    logic          access;
    logic [DW-1:0] mem_m [0:15];
    int            fail_count = 0;
    int            checked    = 0;

    always #5 clock_i = ~clock_i;

    // ****************************************************************
    // Both ends and the pin checker
    // ****************************************************************
    sbsp_if #(.ADDR_W(AW), .LANES(LN), .LANE_W(LW)) sbsp_if_i ();
    sbsp_sram #(.ADDR_W(AW), .LANES(LN), .LANE_W(LW)) sbsp_sram_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .pins(sbsp_if_i),
        .asleep_o(asleep), .access_o(access));
    sbsp_host #(.ADDR_W(AW), .LANES(LN), .LANE_W(LW)) sbsp_host_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .pins(sbsp_if_i),
        .req_valid_i(req_valid), .req_write_i(req_write), .req_burst_i(req_burst),
        .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_lane_en_i(req_lane),
        .linear_order_n_i(linear_n), .flowthru_select_n_i(flow_n), .sleep_i(sleep),
        .req_ready_o(req_ready), .rdata_o(rdata), .rdata_valid_o(rdata_valid));
    sbsp_checker sbsp_checker_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .chip_sel_low_n(sbsp_if_i.chip_sel_low_n), .chip_sel_high(sbsp_if_i.chip_sel_high),
        .proc_addr_strobe_n(sbsp_if_i.proc_addr_strobe_n),
        .ctrl_addr_strobe_n(sbsp_if_i.ctrl_addr_strobe_n),
        .global_write_n(sbsp_if_i.global_write_n), .byte_write_en_n(sbsp_if_i.byte_write_en_n),
        .out_en_n(sbsp_if_i.out_en_n), .sleep_request(sbsp_if_i.sleep_request),
        .flowthru_select_n(sbsp_if_i.flowthru_select_n),
        .host_dq_oe_n(sbsp_if_i.host_dq_oe_n), .dev_dq_oe_n(sbsp_if_i.dev_dq_oe_n));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Holds the request until an edge with ready high takes it
    task automatic req(input logic wr, input logic bu, input logic [AW-1:0] a,
                       input logic [DW-1:0] d, input logic [LN-1:0] ln);
        bit ok;
        int i;
        @(posedge clock_i);
        req_valid <= 1'b1;
        req_write <= wr;
        req_burst <= bu;
        req_addr  <= a;
        req_wdata <= d;
        req_lane  <= ln;
        ok = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            #1 ok = (req_ready === 1'b1);
            @(posedge clock_i);
        end
        req_valid <= 1'b0;
        if (!ok) begin
            fail_count++;
            test_done();
        end
    endtask : req

    task automatic wr_word(input logic [AW-1:0] a, input logic [DW-1:0] d,
                           input logic [LN-1:0] ln);
        int l;
        req(1'b1, 1'b0, a, d, ln);
        for (l = 0; l < LN; l++) begin
            if (ln[l] && !sleep) begin
                mem_m[a][l*LW +: LW] = d[l*LW +: LW];
            end
        end
    endtask : wr_word

    // Latency counted in cycles, the take edge closing cycle 1
    task automatic rd(input logic bu, input logic [AW-1:0] a, input int lat);
        int n;
        int k;
        logic [AW-1:0] ea;
        req(1'b0, bu, a, '0, '0);
        for (n = 1; n < 12; n++) begin
            @(posedge clock_i);
            #1;
            if (rdata_valid === 1'b1) break;
        end
        chk(36'(n + 1), 36'(lat));
        if (rdata_valid !== 1'b1) test_done();
        for (k = 0; k < (bu ? 4 : 1); k++) begin
            if (k > 0) begin
                @(posedge clock_i);
                #1;
                chk({35'h0, rdata_valid}, 36'h1);
                if (k == 1) chk({35'h0, access}, 36'h1);
            end
            ea = a;
            ea[1:0] = linear_n ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
            chk(rdata, mem_m[ea]);
        end
    endtask : rd

    task automatic idle_set(input logic fl, input logic li);
        @(posedge clock_i);
        flow_n   <= fl;
        linear_n <= li;
        repeat (3) @(posedge clock_i);
    endtask : idle_set

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk({35'h0, req_ready}, 36'h1);
        chk({35'h0, sbsp_if_i.chip_sel_low_n}, 36'h1);
        chk({35'h0, sbsp_if_i.dev_dq_oe_n}, 36'h1);
        chk({35'h0, access}, 36'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write_read();
        wr_word(4'h5, 36'h1_2345_6789, 4'hF);
        rd(1'b0, 4'h5, 4);
        idle_set(1'b0, 1'b0);
        rd(1'b0, 4'h5, 3);
        wr_word(4'h5, 36'hA_BCDE_F012, 4'h5);
        rd(1'b0, 4'h5, 3);
        wr_word(4'h5, 36'hF_FFFF_FFFF, 4'h0);
        rd(1'b0, 4'h5, 3);
        $display("test write read done");
    endtask : t_write_read

    // Every order and read mode; each burst read is followed by a single read of word 8
    task automatic t_burst();
        int m;
        for (m = 8; m < 12; m++) begin
            wr_word(AW'(m), {9{4'(m)}}, 4'hF);
        end
        for (m = 0; m < 4; m++) begin
            idle_set(m[1], m[0]);
            rd(1'b1, AW'(9 + m % 3), m[1] ? 4 : 3);
            rd(1'b0, 4'h8, m[1] ? 4 : 3);
        end
        $display("test burst done");
    endtask : t_burst

    task automatic t_sleep();
        @(posedge clock_i);
        sleep <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk({35'h0, asleep}, 36'h1);
        chk({35'h0, sbsp_if_i.dev_dq_oe_n}, 36'h1);
        wr_word(4'hB, 36'h0, 4'hF);
        @(posedge clock_i);
        sleep <= 1'b0;
        repeat (2) @(posedge clock_i);
        rd(1'b0, 4'hB, 4);
        $display("test sleep done");
    endtask : t_sleep

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        t_reset();
        t_write_read();
        t_burst();
        t_sleep();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
